// *** pkg/vcc_pkg.sv ***
// constants for the video clamp control block
// Behaviour
// - black level register low seven bits hold clamp value divided by 16
// - black level removed from 10-bit sample before gain, restored after
// - fine on-time code 0..7 gives 2,4,...,256 cycles per line
// - coarse on-time code gives same doubling 2..256 cycles
// - sync-clamps set: enabled clamp waits for next sync pulse
// - fine direction bits 0,2,4 act only while that clamp is on
// - fine trigger bits 1,3,5 turn fine clamp on for fine on-time
// - coarse direction bits 0,2,4 act only while that clamp is on
// - coarse trigger bits 1,3,5 turn coarse clamp on for coarse on-time
// - oscillator bit zero disables the crystal oscillator
// - bias bit one doubles analog bias currents
// - equalizer bit one enables duty equalizer for converter only
// - triggers are edge detected; host clears bit before retriggering
// - synchronized mode starts clamps on sync edge of chosen polarity
// - sync-clamps clear: enabled clamp switches on immediately
// - polarity zero means low sync pulse, one means high pulse
package vcc_pkg;
  localparam logic [4:0] ADDR_BLACK = 5'h06;
  localparam logic [4:0] ADDR_ONTIME = 5'h07;
  localparam logic [4:0] ADDR_FINE = 5'h08;
  localparam logic [4:0] ADDR_COARSE = 5'h09;
  localparam logic [4:0] ADDR_TIMING = 5'h0a;
  localparam int BLACK_SHIFT = 4;
  localparam int FINE_LSB = 0;
  localparam int COARSE_LSB = 3;
  localparam int SYNC_BIT = 6;
  localparam int OSC_BIT = 0;
  localparam int BIAS_BIT = 1;
  localparam int EQ_BIT = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'h01;
  localparam logic [7:0] ONTIME_MASK = 8'h7f;
  localparam logic [7:0] CLAMP_MASK = 8'h3f;
  localparam logic [7:0] TIMING_MASK = 8'h6b;
  localparam logic [7:0] BLACK_MASK = 8'h7f;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [9:0] SAMPLE_MAX = 10'h3ff;
  typedef enum logic [1:0] {
    VCC_IDLE = 2'b00,
    VCC_WAIT = 2'b01,
    VCC_ON = 2'b10
  } vcc_state_type;
endpackage

// *** logic/vcc_top.sv ***
// clamp sequencer, register file and black-level handling
`timescale 1ns/1ns
`default_nettype none
module vcc_top
  import vcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sync_in,
  input wire logic sync_polarity,
  input wire logic [9:0] sample_in,
  input wire logic [11:0] gain_in,
  output logic [9:0] sample_out,
  output logic [2:0] fine_on,
  output logic [2:0] fine_dir,
  output logic [2:0] coarse_on,
  output logic [2:0] coarse_dir,
  output logic osc_enable,
  output logic bias_double,
  output logic duty_equalizer_enable
);
  logic [7:0] black_q, ontime_q, fine_q, coarse_q, timing_q;
  logic [2:0] fine_arm_q, coarse_arm_q;
  logic [2:0] fine_prev_q, coarse_prev_q;
  logic [8:0] fine_cnt_q, coarse_cnt_q;
  vcc_state_type fine_st_q, coarse_st_q;
  logic sync_prev_q;
  logic sync_edge;
  logic [2:0] fine_trig, coarse_trig;
  logic sync_clamps_enable;

  // code n gives 2^(n+1) cycles; counter loads the count
  function automatic logic [8:0] on_cycles(input logic [2:0] code);
    // shift amount widened so code 7 does not wrap to a one-cycle burst
    on_cycles = 9'(CNT_ONE << ({1'b0, code} + 4'h1));
  endfunction

  function automatic logic [2:0] odd_bits(input logic [7:0] r);
    odd_bits = {r[5], r[3], r[1]};
  endfunction

  function automatic logic [2:0] even_bits(input logic [7:0] r);
    even_bits = {r[4], r[2], r[0]};
  endfunction

  assign sync_clamps_enable = ontime_q[SYNC_BIT];
  // leading edge of the active pulse: falling for low-true, rising for high-true
  assign sync_edge = sync_polarity ? (sync_in & ~sync_prev_q) : (~sync_in & sync_prev_q);
  assign fine_trig = odd_bits(fine_q) & ~fine_prev_q;
  assign coarse_trig = odd_bits(coarse_q) & ~coarse_prev_q;

  // register writes; reserved bits masked so they always read zero
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      black_q <= REG_RESET;
      ontime_q <= REG_RESET;
      fine_q <= REG_RESET;
      coarse_q <= REG_RESET;
      timing_q <= TIMING_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_BLACK: black_q <= reg_wdata & BLACK_MASK;
        ADDR_ONTIME: ontime_q <= reg_wdata & ONTIME_MASK;
        ADDR_FINE: fine_q <= reg_wdata & CLAMP_MASK;
        ADDR_COARSE: coarse_q <= reg_wdata & CLAMP_MASK;
        ADDR_TIMING: timing_q <= reg_wdata & TIMING_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= REG_RESET;
    else
    begin
      case (reg_addr)
        ADDR_BLACK: reg_rdata <= black_q;
        ADDR_ONTIME: reg_rdata <= ontime_q;
        ADDR_FINE: reg_rdata <= fine_q;
        ADDR_COARSE: reg_rdata <= coarse_q;
        ADDR_TIMING: reg_rdata <= timing_q;
        default: reg_rdata <= REG_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      osc_enable <= 1'b1;
      bias_double <= 1'b0;
      duty_equalizer_enable <= 1'b0;
    end
    else
    begin
      osc_enable <= timing_q[OSC_BIT];
      bias_double <= timing_q[BIAS_BIT];
      duty_equalizer_enable <= timing_q[EQ_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fine_prev_q <= 3'h0;
      coarse_prev_q <= 3'h0;
      sync_prev_q <= 1'b0;
    end
    else
    begin
      fine_prev_q <= odd_bits(fine_q);
      coarse_prev_q <= odd_bits(coarse_q);
      sync_prev_q <= sync_in;
    end
  end

  // fine group: one shared down-counter; a new trigger adds a clamp to the running burst
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fine_st_q <= VCC_IDLE;
      fine_cnt_q <= 9'h000;
      fine_arm_q <= 3'h0;
    end
    else
    begin
      case (fine_st_q)
        VCC_IDLE:
          if (fine_trig != 3'h0)
          begin
            fine_arm_q <= fine_trig;
            fine_cnt_q <= on_cycles(ontime_q[FINE_LSB +: 3]);
            if (sync_clamps_enable)
              fine_st_q <= VCC_WAIT;
            else
              fine_st_q <= VCC_ON;
          end
        VCC_WAIT:
        begin
          fine_arm_q <= fine_arm_q | fine_trig;
          if (sync_edge)
            fine_st_q <= VCC_ON;
        end
        VCC_ON:
        begin
          fine_arm_q <= fine_arm_q | fine_trig;
          fine_cnt_q <= fine_cnt_q - CNT_ONE;
          if (fine_cnt_q == CNT_ONE)
          begin
            fine_st_q <= VCC_IDLE;
            fine_arm_q <= 3'h0;
          end
        end
        default: fine_st_q <= VCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      coarse_st_q <= VCC_IDLE;
      coarse_cnt_q <= 9'h000;
      coarse_arm_q <= 3'h0;
    end
    else
    begin
      case (coarse_st_q)
        VCC_IDLE:
          if (coarse_trig != 3'h0)
          begin
            coarse_arm_q <= coarse_trig;
            coarse_cnt_q <= on_cycles(ontime_q[COARSE_LSB +: 3]);
            if (sync_clamps_enable)
              coarse_st_q <= VCC_WAIT;
            else
              coarse_st_q <= VCC_ON;
          end
        VCC_WAIT:
        begin
          coarse_arm_q <= coarse_arm_q | coarse_trig;
          if (sync_edge)
            coarse_st_q <= VCC_ON;
        end
        VCC_ON:
        begin
          coarse_arm_q <= coarse_arm_q | coarse_trig;
          coarse_cnt_q <= coarse_cnt_q - CNT_ONE;
          if (coarse_cnt_q == CNT_ONE)
          begin
            coarse_st_q <= VCC_IDLE;
            coarse_arm_q <= 3'h0;
          end
        end
        default: coarse_st_q <= VCC_IDLE;
      endcase
    end
  end

  // clamp outputs registered; direction forced low while the clamp is off
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fine_on <= 3'h0;
      fine_dir <= 3'h0;
      coarse_on <= 3'h0;
      coarse_dir <= 3'h0;
    end
    else
    begin
      fine_on <= (fine_st_q == VCC_ON) ? fine_arm_q : 3'h0;
      fine_dir <= (fine_st_q == VCC_ON) ? (fine_arm_q & even_bits(fine_q)) : 3'h0;
      coarse_on <= (coarse_st_q == VCC_ON) ? coarse_arm_q : 3'h0;
      coarse_dir <= (coarse_st_q == VCC_ON) ? (coarse_arm_q & even_bits(coarse_q)) : 3'h0;
    end
  end

  // gain in 4.8 fixed point; saturates rather than wrapping at full scale
  logic [11:0] black_full;
  logic signed [12:0] offset_s;
  logic signed [25:0] scaled_s;
  logic signed [17:0] result_s;
  assign black_full = 12'({black_q[6:0], 4'h0});
  assign offset_s = 13'(signed'({3'b000, sample_in}) - signed'({1'b0, black_full}));
  assign scaled_s = offset_s * signed'({1'b0, gain_in});
  assign result_s = 18'(scaled_s >>> 8) + signed'({6'h00, black_full});

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      sample_out <= 10'h000;
    else if (result_s < 0)
      sample_out <= 10'h000;
    else if (result_s > signed'({8'h00, SAMPLE_MAX}))
      sample_out <= SAMPLE_MAX;
    else
      sample_out <= result_s[9:0];
  end
endmodule // vcc_top
`default_nettype wire

// *** tb/vcc_monitor.sv ***
// assertion checker on the clamp control ports
`timescale 1ns/1ns
`default_nettype none
module vcc_monitor
  import vcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic sync_in,
  input wire logic sync_polarity,
  input wire logic [9:0] sample_in,
  input wire logic [11:0] gain_in,
  input wire logic [9:0] sample_out,
  input wire logic [2:0] fine_on,
  input wire logic [2:0] fine_dir,
  input wire logic [2:0] coarse_on,
  input wire logic [2:0] coarse_dir,
  input wire logic osc_enable,
  input wire logic bias_double,
  input wire logic duty_equalizer_enable
);
  logic sync_q, fine1_q, sy_q;
  logic [3:0] since_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // cycles since the last sync edge of the chosen polarity, saturating
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sync_q <= 1'b0;
      fine1_q <= 1'b0;
      sy_q <= 1'b0;
      since_q <= 4'hf;
    end
    else
    begin
      if (reg_wr && reg_addr == ADDR_ONTIME)
        sync_q <= reg_wdata[SYNC_BIT];
      if (reg_wr && reg_addr == ADDR_FINE)
        fine1_q <= reg_wdata[1];
      sy_q <= sync_in;
      if ((sync_in ^ sy_q) && sync_in == sync_polarity)
        since_q <= 4'h0;
      else if (since_q != 4'hf)
        since_q <= since_q + 4'h1;
    end
  end
  property p_fdir;
    (fine_dir & ~fine_on) == 3'b000;
  endproperty
  a_fdir: assert property (p_fdir) else $error("fine dir while off");
  property p_cdir;
    (coarse_dir & ~coarse_on) == 3'b000;
  endproperty
  a_cdir: assert property (p_cdir) else $error("coarse dir while off");
  property p_osc;
    reg_wr && reg_addr == ADDR_TIMING |-> ##2 osc_enable == $past(reg_wdata[OSC_BIT], 2);
  endproperty
  a_osc: assert property (p_osc) else $error("osc bit");
  property p_bias;
    reg_wr && reg_addr == ADDR_TIMING |-> ##2 bias_double == $past(reg_wdata[BIAS_BIT], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias bit");
  property p_eq;
    reg_wr && reg_addr == ADDR_TIMING |-> ##2 duty_equalizer_enable == $past(reg_wdata[EQ_BIT], 2);
  endproperty
  a_eq: assert property (p_eq) else $error("equalizer bit");
  property p_wait;
    sync_q && $rose(fine_on != 3'b000) |-> since_q <= 4'h5;
  endproperty
  a_wait: assert property (p_wait) else $error("clamp on without sync");
  property p_now;
    reg_wr && reg_addr == ADDR_FINE && reg_wdata[1] && !fine1_q && !sync_q && fine_on == 3'b000 |-> ##[2:4] fine_on[0];
  endproperty
  a_now: assert property (p_now) else $error("clamp did not start");
  property p_unity;
    gain_in == 12'h100 |=> sample_out == $past(sample_in);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain changed sample");
endmodule // vcc_monitor
`default_nettype wire

// *** tb/vcc_sync_src.sv ***
// model of the external sync source
`timescale 1ns/1ns
`default_nettype none
module vcc_sync_src
(
  input wire logic ref_clk,
  input wire logic sync_polarity,
  input wire logic pulse_go,
  output logic sync_in
);
  logic [1:0] hold_q = 2'h0;
  always_ff @(posedge ref_clk)
    if (pulse_go)
      hold_q <= 2'h3;
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  // the pin rests at the inactive level between pulses
  assign sync_in = (hold_q != 2'h0) ? sync_polarity : ~sync_polarity;
endmodule // vcc_sync_src
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the clamp control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import vcc_pkg::*;
;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, sync_polarity = 1'b0, pulse_go = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [9:0] sample_in = 10'h155;
  logic [11:0] gain_in = 12'h100;
  logic sync_in, osc_enable, bias_double, duty_equalizer_enable;
  logic [7:0] reg_rdata;
  logic [9:0] sample_out;
  logic [2:0] fine_on, fine_dir, coarse_on, coarse_dir;
  logic [9:0] smp [4] = '{10'h064, 10'h064, 10'h3ff, 10'h000};
  logic [11:0] gn [4] = '{12'h200, 12'h000, 12'h200, 12'h200};
  logic [9:0] res [4] = '{10'h088, 10'h040, 10'h3ff, 10'h000};
  int bad_count = 0, tests_run = 0, nf, nc, nfd, ncd;
  always #5 ref_clk = ~ref_clk;
  vcc_top dut (.ref_clk, .reset, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .sync_in, .sync_polarity, .sample_in,
    .gain_in, .sample_out, .fine_on, .fine_dir, .coarse_on, .coarse_dir, .osc_enable, .bias_double,
    .duty_equalizer_enable);
  vcc_sync_src src (.ref_clk, .sync_polarity, .pulse_go, .sync_in);
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(negedge ref_clk);
    chk(10'(reg_rdata), 10'(e));
  endtask
  task automatic count(input int n);
    nf = 0;
    nc = 0;
    nfd = 0;
    ncd = 0;
    repeat (n) @(negedge ref_clk)
    begin
      nf += int'(fine_on != 3'b000);
      nc += int'(coarse_on != 3'b000);
      nfd += int'(fine_dir === 3'b001);
      ncd += int'(coarse_dir === 3'b110);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    chk(10'(osc_enable), 10'h001);
    rd(ADDR_TIMING, TIMING_RESET);
    rd(5'h0b, 8'h00);
    wr(ADDR_BLACK, 8'hff);
    rd(ADDR_BLACK, BLACK_MASK);
    wr(ADDR_FINE, 8'hc0);
    rd(ADDR_FINE, 8'h00);
    wr(ADDR_TIMING, 8'hff);
    rd(ADDR_TIMING, TIMING_MASK);
    chk(10'({osc_enable, bias_double, duty_equalizer_enable}), 10'h007);
    wr(ADDR_TIMING, 8'h00);
    rd(ADDR_TIMING, 8'h00);
    chk(10'({osc_enable, bias_double, duty_equalizer_enable}), 10'h000);
    wr(ADDR_BLACK, 8'h04);
    foreach (smp[i])
    begin
      @(posedge ref_clk);
      sample_in <= smp[i];
      gain_in <= gn[i];
      repeat (2) @(negedge ref_clk);
      chk(sample_out, res[i]);
    end
    gain_in <= 12'h100;
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_ONTIME, 8'(c * 9));
      wr(ADDR_FINE, 8'h2b);
      count((2 << c) + 12);
      chk(10'(nf), 10'(2 << c));
      chk(10'(nfd), 10'(2 << c));
      wr(ADDR_COARSE, 8'h3e);
      count((2 << c) + 12);
      chk(10'(nc), 10'(2 << c));
      chk(10'(ncd), 10'(2 << c));
      wr(ADDR_FINE, 8'h00);
      wr(ADDR_COARSE, 8'h00);
    end
    wr(ADDR_ONTIME, 8'h00);
    wr(ADDR_FINE, 8'h02);
    count(12);
    wr(ADDR_FINE, 8'h02);
    count(12);
    chk(10'(nf), 10'h000);
    wr(ADDR_FINE, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge ref_clk);
      sync_polarity <= p[0];
      wr(ADDR_ONTIME, 8'h40);
      wr(ADDR_FINE, 8'h02);
      count(10);
      chk(10'(nf), 10'h000);
      @(posedge ref_clk);
      pulse_go <= 1'b1;
      @(posedge ref_clk);
      pulse_go <= 1'b0;
      count(12);
      chk(10'(nf), 10'h002);
      wr(ADDR_FINE, 8'h00);
    end
    give_verdict();
  end
endmodule // tb_top
bind vcc_top vcc_monitor mon (.ref_clk, .reset, .reg_wr, .reg_addr, .reg_wdata, .sync_in, .sync_polarity, .sample_in,
  .gain_in, .sample_out, .fine_on, .fine_dir, .coarse_on, .coarse_dir, .osc_enable, .bias_double, .duty_equalizer_enable);
`default_nettype wire
